// ---- rtl/irq_entry_pkg.sv ----
// Function
// RULE1: Timer, serial, synchronous serial, wake-up and converter requests are maskable interrupts.
// RULE2: Non-maskable request has top priority, raised on a falling edge of its pin.
// RULE3: Entry first lowers the interrupt stack pointer by four.
// RULE4: Entry then stores program counter and status word onto the interrupt stack.
// RULE5: Entry then clears global enable, trace pending and trace bits of the status word.
// RULE6: Entry then takes the vector number from the vector number register.
// RULE7: Vector doubled plus base pointer addresses the table entry, loaded into program counter.
// RULE8: Exception return reloads program counter and status word, raises stack pointer by four.
// RULE9: Each two-byte table entry gives address bits 1 to 16.
// RULE10: Routine address is the entry with a zero above and a zero below.
// RULE11: Base pointer is 21 bits; upper five bits and bit zero always read zero.
// RULE12: Table holds 32 word entries for vectors 0 to 31.
// RULE13: Maskable request n uses vector 16 plus n.
// RULE14: Non-maskable request uses vector 1; vectors 5 to 10 are traps.
// RULE15: Software places only routine addresses 0000 to BFFF in table entries.
// RULE16: Software loads the base pointer after reset before enabling interrupts.
// RULE17: Highest-numbered pending maskable request is served first.
// RULE18: Maskable requests are taken only when global and local enables are both one.
// RULE19: Vector register shows the highest pending enabled source when the entry reads it.
package irq_entry_pkg;

	// Register word indices on the plain port
	localparam logic [2:0] REG_BASE    = 3'h0;
	localparam logic [2:0] REG_ISP     = 3'h1;
	localparam logic [2:0] REG_PSW     = 3'h2;
	localparam logic [2:0] REG_IRQ_EN  = 3'h3;
	localparam logic [2:0] REG_VECTOR  = 3'h4;
	localparam logic [2:0] REG_STATUS  = 3'h5;

	// Status word bit positions
	localparam int PSW_T = 1;
	localparam int PSW_E = 9;
	localparam int PSW_P = 10;
	localparam int PSW_I = 11;

	// Reset values
	localparam logic [15:0] BASE_RST   = 16'h0000;
	localparam logic [15:0] ISP_RST    = 16'h0000;
	localparam logic [15:0] PSW_RST    = 16'h0000;
	localparam logic [15:0] IRQ_EN_RST = 16'h0000;

	// Vector numbers
	localparam logic [4:0] VEC_NMI     = 5'h01;
	localparam logic [4:0] VEC_SVC     = 5'h05;
	localparam logic [4:0] VEC_DVZ     = 5'h06;
	localparam logic [4:0] VEC_FLAG    = 5'h07;
	localparam logic [4:0] VEC_BPT     = 5'h08;
	localparam logic [4:0] VEC_TRACE   = 5'h09;
	localparam logic [4:0] VEC_UNDEF   = 5'h0a;
	localparam logic [4:0] VEC_MASK0   = 5'h10;

	// Stack frame size in bytes and word step inside it
	localparam logic [15:0] FRAME_BYTES = 16'h0004;
	localparam logic [15:0] WORD_BYTES  = 16'h0002;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_DEC     = 4'b0001,
		ST_PUSH_PC = 4'b0010,
		ST_PUSH_SW = 4'b0011,
		ST_CLR     = 4'b0100,
		ST_VEC     = 4'b0101,
		ST_FETCH   = 4'b0110,
		ST_LOAD    = 4'b0111,
		ST_RET_PC  = 4'b1000,
		ST_RET_SW  = 4'b1001,
		ST_RET_END = 4'b1010
	} entry_state_t;

	// Table entry to full routine address, zero above and below
	function automatic logic [20:0] entry_to_addr(input logic [15:0] entry);
		entry_to_addr = {4'h0, entry, 1'b0}; // [RULE9] [RULE10]
	endfunction : entry_to_addr

endpackage : irq_entry_pkg

// ---- rtl/vector_picker.sv ----
`timescale 1ns/100ps
`default_nettype none
module vector_picker (
	// Pending sources
	input  wire logic        nmi_i,
	input  wire logic [15:0] req_i,
	// Chosen source
	output logic             valid_o,
	output logic [4:0]       vector_o
);

	// Non-maskable first, then the highest-numbered maskable request
	always_comb begin
		valid_o  = 1'b0;
		vector_o = irq_entry_pkg::VEC_MASK0;
		if (nmi_i) begin
			valid_o  = 1'b1;
			vector_o = irq_entry_pkg::VEC_NMI; // [RULE2] [RULE14]
		end else begin
			for (int n = 0; n < 16; n++) begin
				if (req_i[n]) begin
					valid_o  = 1'b1;
					vector_o = irq_entry_pkg::VEC_MASK0 + 5'(n); // [RULE13] [RULE17]
				end
			end
		end
	end

endmodule : vector_picker
`default_nettype wire

// ---- rtl/irq_entry_dispatch.sv ----
`timescale 1ns/100ps
`default_nettype none
module irq_entry_dispatch (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	// Register port
	input  wire logic [2:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic [15:0]      reg_rdata_o,
	// Interrupt sources
	input  wire logic [15:0] irq_i,
	input  wire logic        nmi_n_i,
	// Core side
	input  wire logic [20:0] pc_i,
	input  wire logic        exc_return_i,
	output logic             pc_load_o,
	output logic [20:0]      pc_value_o,
	output logic             busy_o,
	// Memory port, read data answered in the cycle the read strobe stands
	output logic [20:0]      mem_addr_o,
	output logic [15:0]      mem_wdata_o,
	output logic             mem_we_o,
	output logic             mem_re_o,
	input  wire logic [15:0] mem_rdata_i
);

	typedef struct packed {
		irq_entry_pkg::entry_state_t st;
		logic [15:0] base;
		logic [15:0] irq_stack_pointer;
		logic [15:0] psw;
		logic [15:0] irq_en;
		logic [4:0]  vec;
		logic        nmi_meta;
		logic        nmi_sync;
		logic        nmi_prev;
		logic        nmi_pend;
		logic [15:0] rdata;
		logic [20:0] mem_addr;
		logic [15:0] mem_wdata;
		logic        mem_we;
		logic        mem_re;
		logic        pc_load;
		logic [20:0] pc_value;
		logic        busy;
	} unit_state_t;

	unit_state_t s;
	unit_state_t next_s;

	logic        pick_valid;
	logic [4:0]  pick_vec;
	logic [15:0] live_req;
	logic        nmi_fall;
	logic        mask_ok;

	// Only requests enabled in the mask take part in the choice
	assign live_req = irq_i & s.irq_en; // [RULE1]
	assign nmi_fall = s.nmi_prev & ~s.nmi_sync; // [RULE2]
	assign mask_ok  = s.psw[irq_entry_pkg::PSW_I] & s.psw[irq_entry_pkg::PSW_E];

	vector_picker u_picker (
		.nmi_i    (s.nmi_pend),
		.req_i    (live_req),
		.valid_o  (pick_valid),
		.vector_o (pick_vec)
	);

	// Next-state logic for the whole unit
	always_comb begin
		next_s          = s;
		next_s.mem_we   = 1'b0;
		next_s.mem_re   = 1'b0;
		next_s.pc_load  = 1'b0;
		next_s.rdata    = 16'h0000;
		// Pin passes two flops before the edge detector sees it
		next_s.nmi_meta = nmi_n_i;
		next_s.nmi_sync = s.nmi_meta;
		next_s.nmi_prev = s.nmi_sync;

		// Register reads, data valid the cycle after the strobe
		if (reg_re_i) begin
			unique case (reg_addr_i)
				irq_entry_pkg::REG_BASE:   next_s.rdata = s.base;
				irq_entry_pkg::REG_ISP:    next_s.rdata = s.irq_stack_pointer;
				irq_entry_pkg::REG_PSW:    next_s.rdata = s.psw;
				irq_entry_pkg::REG_IRQ_EN: next_s.rdata = s.irq_en;
				irq_entry_pkg::REG_VECTOR: next_s.rdata = {11'h000, s.vec};
				irq_entry_pkg::REG_STATUS: next_s.rdata = {10'h000, s.nmi_pend, s.st != irq_entry_pkg::ST_IDLE, s.st};
				default:                   next_s.rdata = 16'h0000;
			endcase
		end

		// Register writes; stack pointer and status word are locked during a sequence
		if (reg_we_i) begin
			unique case (reg_addr_i)
				irq_entry_pkg::REG_BASE:   next_s.base = {reg_wdata_i[15:1], 1'b0}; // [RULE11]
				irq_entry_pkg::REG_IRQ_EN: next_s.irq_en = reg_wdata_i;
				irq_entry_pkg::REG_ISP: begin
					if (s.st == irq_entry_pkg::ST_IDLE) begin
						next_s.irq_stack_pointer = reg_wdata_i;
					end
				end
				irq_entry_pkg::REG_PSW: begin
					if (s.st == irq_entry_pkg::ST_IDLE) begin
						next_s.psw = reg_wdata_i;
					end
				end
				default: ;
			endcase
		end

		// Entry and return sequencer
		unique case (s.st)
			irq_entry_pkg::ST_IDLE: begin
				if (exc_return_i) begin
					next_s.mem_re   = 1'b1;
					next_s.mem_addr = {5'h00, s.irq_stack_pointer};
					next_s.st       = irq_entry_pkg::ST_RET_PC;
				end else if (s.nmi_pend || (pick_valid && mask_ok)) begin // [RULE18] [RULE2]
					next_s.st = irq_entry_pkg::ST_DEC;
				end
			end
			irq_entry_pkg::ST_DEC: begin
				next_s.irq_stack_pointer = s.irq_stack_pointer - irq_entry_pkg::FRAME_BYTES; // [RULE3]
				next_s.st  = irq_entry_pkg::ST_PUSH_PC;
			end
			irq_entry_pkg::ST_PUSH_PC: begin
				// Program counter word at the lower address, status word above it
				next_s.mem_we    = 1'b1;
				next_s.mem_addr  = {5'h00, s.irq_stack_pointer};
				next_s.mem_wdata = pc_i[16:1]; // [RULE4]
				next_s.st        = irq_entry_pkg::ST_PUSH_SW;
			end
			irq_entry_pkg::ST_PUSH_SW: begin
				next_s.mem_we    = 1'b1;
				next_s.mem_addr  = {5'h00, s.irq_stack_pointer + irq_entry_pkg::WORD_BYTES};
				next_s.mem_wdata = s.psw; // [RULE4]
				next_s.st        = irq_entry_pkg::ST_CLR;
			end
			irq_entry_pkg::ST_CLR: begin
				next_s.psw[irq_entry_pkg::PSW_I] = 1'b0; // [RULE5]
				next_s.psw[irq_entry_pkg::PSW_P] = 1'b0; // [RULE5]
				next_s.psw[irq_entry_pkg::PSW_T] = 1'b0; // [RULE5]
				next_s.st = irq_entry_pkg::ST_VEC;
			end
			irq_entry_pkg::ST_VEC: begin
				// Sampled now, so a request that rose during the push still wins
				next_s.vec = pick_valid ? pick_vec : irq_entry_pkg::VEC_MASK0; // [RULE6] [RULE19]
				if (pick_vec == irq_entry_pkg::VEC_NMI) begin
					next_s.nmi_pend = 1'b0;
				end
				next_s.st = irq_entry_pkg::ST_FETCH;
			end
			irq_entry_pkg::ST_FETCH: begin
				next_s.mem_re   = 1'b1;
				next_s.mem_addr = {5'h00, s.base} + {15'h0000, s.vec, 1'b0}; // [RULE7] [RULE12]
				next_s.st       = irq_entry_pkg::ST_LOAD;
			end
			irq_entry_pkg::ST_LOAD: begin
				next_s.pc_load  = 1'b1;
				next_s.pc_value = irq_entry_pkg::entry_to_addr(mem_rdata_i); // [RULE7] [RULE10]
				next_s.st       = irq_entry_pkg::ST_IDLE;
			end
			irq_entry_pkg::ST_RET_PC: begin
				next_s.pc_value = irq_entry_pkg::entry_to_addr(mem_rdata_i); // [RULE8]
				next_s.mem_re   = 1'b1;
				next_s.mem_addr = {5'h00, s.irq_stack_pointer + irq_entry_pkg::WORD_BYTES};
				next_s.st       = irq_entry_pkg::ST_RET_SW;
			end
			irq_entry_pkg::ST_RET_SW: begin
				next_s.psw = mem_rdata_i; // [RULE8]
				next_s.st  = irq_entry_pkg::ST_RET_END;
			end
			irq_entry_pkg::ST_RET_END: begin
				next_s.irq_stack_pointer     = s.irq_stack_pointer + irq_entry_pkg::FRAME_BYTES; // [RULE8]
				next_s.pc_load = 1'b1;
				next_s.st      = irq_entry_pkg::ST_IDLE;
			end
			default: next_s.st = irq_entry_pkg::ST_IDLE;
		endcase

		// A fresh edge beats the clear in the same cycle
		if (nmi_fall) begin
			next_s.nmi_pend = 1'b1; // [RULE2]
		end

		// Busy flag registered so the output comes straight from a flop
		next_s.busy = (next_s.st != irq_entry_pkg::ST_IDLE);
	end

	// State register; pin flops reset to idle-high so reset raises no edge
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s          <= '0;
			s.st       <= irq_entry_pkg::ST_IDLE;
			s.base     <= irq_entry_pkg::BASE_RST;
			s.irq_stack_pointer      <= irq_entry_pkg::ISP_RST;
			s.psw      <= irq_entry_pkg::PSW_RST;
			s.irq_en   <= irq_entry_pkg::IRQ_EN_RST;
			s.nmi_meta <= 1'b1;
			s.nmi_sync <= 1'b1;
			s.nmi_prev <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops
	assign reg_rdata_o = s.rdata;
	assign pc_load_o   = s.pc_load;
	assign pc_value_o  = s.pc_value;
	assign busy_o      = s.busy;
	assign mem_addr_o  = s.mem_addr;
	assign mem_wdata_o = s.mem_wdata;
	assign mem_we_o    = s.mem_we;
	assign mem_re_o    = s.mem_re;

	// Checks on the sequencer
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	a_isp_drop_four: assert property ((s.st == irq_entry_pkg::ST_DEC) |=> (s.irq_stack_pointer == $past(s.irq_stack_pointer) - 16'h0004)) // [RULE3]
		else $error("stack pointer not lowered by four");
	a_push_pc_psw: assert property ((s.st == irq_entry_pkg::ST_DEC) |=> ##1 (s.mem_we && s.mem_addr == {5'h00, s.irq_stack_pointer})
		##1 (s.mem_we && s.mem_wdata == $past(s.psw, 2))) // [RULE4]
		else $error("entry push sequence wrong");
	a_psw_bits_clear: assert property ((s.st == irq_entry_pkg::ST_CLR) |=> (!s.psw[irq_entry_pkg::PSW_I]
		&& !s.psw[irq_entry_pkg::PSW_P] && !s.psw[irq_entry_pkg::PSW_T])) // [RULE5]
		else $error("status bits not cleared on entry");
	a_table_address: assert property ((s.st == irq_entry_pkg::ST_FETCH) |=> (s.mem_re
		&& s.mem_addr == {5'h00, s.base} + {15'h0000, s.vec, 1'b0})) // [RULE7]
		else $error("table address wrong");
	a_pc_shape: assert property (s.pc_load |-> (s.pc_value[0] == 1'b0 && s.pc_value[20:17] == 4'h0)) // [RULE10]
		else $error("routine address not zero padded");
	a_base_low_zero: assert property (s.base[0] == 1'b0) // [RULE11]
		else $error("base pointer bit zero set");
	a_isp_rise_four: assert property ((s.st == irq_entry_pkg::ST_RET_END) |=> (s.irq_stack_pointer == $past(s.irq_stack_pointer) + 16'h0004
		&& s.pc_load)) // [RULE8]
		else $error("return did not raise stack pointer by four");
	a_mask_blocks: assert property ((s.st == irq_entry_pkg::ST_IDLE && !s.nmi_pend && !mask_ok && !exc_return_i)
		|=> (s.st == irq_entry_pkg::ST_IDLE)) // [RULE18]
		else $error("maskable request taken while disabled");
	a_nmi_edge_pend: assert property (nmi_fall |=> s.nmi_pend) // [RULE2]
		else $error("falling edge not latched");
	a_nmi_first: assert property ((s.st == irq_entry_pkg::ST_VEC && s.nmi_pend) |=> (s.vec == 5'h01)) // [RULE2]
		else $error("non-maskable request not served first");
	a_mask_vector: assert property ((s.st == irq_entry_pkg::ST_VEC && !s.nmi_pend && pick_valid)
		|=> (s.vec >= 5'h10)) // [RULE13]
		else $error("maskable vector below sixteen");
	a_entry_length: assert property ((s.st == irq_entry_pkg::ST_IDLE ##1 s.st == irq_entry_pkg::ST_DEC)
		|-> ##7 s.pc_load) // [RULE6]
		else $error("entry sequence length wrong");

	c_nmi_entry: cover property (s.st == irq_entry_pkg::ST_VEC && s.nmi_pend ##3 s.pc_load);
	c_mask_entry: cover property (s.st == irq_entry_pkg::ST_VEC && !s.nmi_pend ##3 s.pc_load);
	c_return: cover property (s.st == irq_entry_pkg::ST_RET_END ##1 s.pc_load);

endmodule : irq_entry_dispatch
`default_nettype wire

// ---- tb/irq_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module irq_mem_model #(
	parameter int TABLE_BASE = 256
) (
	// Clock
	input  wire logic        mclk_i,
	// Memory port from the block
	input  wire logic [20:0] mem_addr_i,
	input  wire logic [15:0] mem_wdata_i,
	input  wire logic        mem_we_i,
	input  wire logic        mem_re_i,
	// Read data back to the block
	output logic [15:0]      mem_rdata_o
);
	logic [15:0] words [int];

	// Dispatch table: 32 word entries, each routine address inside program space
	initial begin
		for (int v = 0; v < 32; v++) begin
			words[TABLE_BASE / 2 + v] = 16'h1000 + 16'(v);
		end
	end

	// Word memory writes on the clock edge
	always @(posedge mclk_i) begin
		if (mem_we_i) begin
			words[int'(mem_addr_i[20:1])] = mem_wdata_i;
		end
	end

	// Read answer stands while the strobe does; otherwise a junk word so stale data never passes
	always @* begin
		if (mem_re_i && words.exists(int'(mem_addr_i[20:1]))) begin
			mem_rdata_o = words[int'(mem_addr_i[20:1])];
		end else if (mem_re_i) begin
			mem_rdata_o = 16'hffff;
		end else begin
			mem_rdata_o = 16'hdead;
		end
	end
endmodule : irq_mem_model
`default_nettype wire

// ---- tb/interrupt_entry_dispatch_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module interrupt_entry_dispatch_test;
	localparam logic [15:0] PSW_IE  = (16'h0001 << irq_entry_pkg::PSW_I) | (16'h0001 << irq_entry_pkg::PSW_E);
	localparam logic [15:0] PSW_ALL = PSW_IE | (16'h0001 << irq_entry_pkg::PSW_P) | (16'h0001 << irq_entry_pkg::PSW_T);
	localparam logic [15:0] TBL     = 16'h0100;
	localparam logic [15:0] STK     = 16'h0400;
	localparam logic [20:0] PC_NOW  = 21'h00abc4;

	logic        mclk_i, sys_rst_i, reg_we_i, reg_re_i, nmi_n_i, exc_return_i;
	logic        pc_load_o, busy_o, mem_we_o, mem_re_o;
	logic [2:0]  reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, irq_i, mem_wdata_o, mem_rdata_i, rd;
	logic [20:0] pc_i, pc_value_o, mem_addr_o;
	int          error_cnt, total_checks;

	irq_entry_dispatch dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.irq_i(irq_i), .nmi_n_i(nmi_n_i), .pc_i(pc_i), .exc_return_i(exc_return_i), .pc_load_o(pc_load_o),
		.pc_value_o(pc_value_o), .busy_o(busy_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_rdata_i(mem_rdata_i));

	irq_mem_model #(.TABLE_BASE(int'(TBL))) mem_u (.mclk_i(mclk_i), .mem_addr_i(mem_addr_o),
		.mem_wdata_i(mem_wdata_o), .mem_we_i(mem_we_o), .mem_re_i(mem_re_o), .mem_rdata_o(mem_rdata_i));

	// Free-running CPU clock, 100 ns period
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk16

	task automatic chk21(input string name, input logic [20:0] exp, input logic [20:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk21

	// One-cycle write strobe
	task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_we_i    <= 1'b1;
		@(posedge mclk_i);
		reg_we_i    <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe
	task automatic reg_chk(input string name, input logic [2:0] a, input logic [15:0] exp);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge mclk_i);
		reg_re_i   <= 1'b0;
		@(negedge mclk_i);
		chk16(name, exp, reg_rdata_o);
	endtask : reg_chk

	// Bounded wait for the program counter load pulse
	task automatic wait_load;
		int n;
		n = 0;
		@(negedge mclk_i);
		while (pc_load_o !== 1'b1 && n < 40) begin
			@(negedge mclk_i);
			n++;
		end
		total_checks++;
		if (n >= 40) begin
			error_cnt++;
			$display("Error pc_load_o expected 1 seen 0");
		end
	endtask : wait_load

	// Blocked requests: sequencer must stay idle
	task automatic chk_idle(input string name);
		repeat (20) @(negedge mclk_i);
		chk16(name, 16'h0000, {15'h0000, busy_o});
	endtask : chk_idle

	task automatic print_verdict;
		$display("Checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	// Watchdog, well beyond the roughly 300 cycles the tests need
	initial begin
		repeat (3000) @(posedge mclk_i);
		error_cnt++;
		print_verdict();
	end

	initial begin
		error_cnt = 0;
		total_checks = 0;
		sys_rst_i = 1'b1;
		{reg_we_i, reg_re_i, exc_return_i} = 3'h0;
		nmi_n_i = 1'b1;
		reg_addr_i = 3'h0;
		reg_wdata_i = 16'h0000;
		irq_i = 16'h0000;
		pc_i = PC_NOW;
		repeat (8) @(posedge mclk_i);
		sys_rst_i <= 1'b0;

		reg_chk("base reset", irq_entry_pkg::REG_BASE, irq_entry_pkg::BASE_RST);
		reg_chk("psw reset", irq_entry_pkg::REG_PSW, irq_entry_pkg::PSW_RST);
		reg_chk("unmapped", 3'h6, 16'h0000);
		reg_wr(irq_entry_pkg::REG_BASE, 16'hffff);
		reg_chk("base low bit", irq_entry_pkg::REG_BASE, 16'hfffe);
		$display("Test registers done");

		// Software loads the table pointer and stack before enabling requests
		reg_wr(irq_entry_pkg::REG_BASE, TBL);
		reg_wr(irq_entry_pkg::REG_ISP, STK);
		reg_wr(irq_entry_pkg::REG_IRQ_EN, 16'hffff);
		irq_i <= 16'h0208;
		reg_wr(irq_entry_pkg::REG_PSW, PSW_ALL);
		wait_load();
		chk21("entry pc", {4'h0, 16'h1000 + 16'd25, 1'b0}, pc_value_o);
		reg_chk("entry isp", irq_entry_pkg::REG_ISP, STK - 16'h0004);
		chk16("frame pc", PC_NOW[16:1], mem_u.words[int'(STK - 16'h0004) / 2]);
		chk16("frame psw", PSW_ALL, mem_u.words[int'(STK - 16'h0002) / 2]);
		reg_chk("entry psw", irq_entry_pkg::REG_PSW, PSW_IE & ~(16'h0001 << irq_entry_pkg::PSW_I));
		reg_chk("entry vector", irq_entry_pkg::REG_VECTOR, 16'd25);
		chk_idle("blocked global");
		reg_wr(irq_entry_pkg::REG_PSW, 16'h0001 << irq_entry_pkg::PSW_I);
		chk_idle("blocked local");
		$display("Test entry done");

		irq_i <= 16'h0000;
		@(posedge mclk_i);
		exc_return_i <= 1'b1;
		@(posedge mclk_i);
		exc_return_i <= 1'b0;
		wait_load();
		chk21("return pc", PC_NOW, pc_value_o);
		reg_chk("return isp", irq_entry_pkg::REG_ISP, STK);
		reg_chk("return psw", irq_entry_pkg::REG_PSW, PSW_ALL);
		$display("Test return done");

		// Every maskable line alone, each mapped to its own vector
		reg_wr(irq_entry_pkg::REG_PSW, 16'h0000);
		for (int n = 0; n < 16; n++) begin
			irq_i <= 16'h0001 << n;
			reg_wr(irq_entry_pkg::REG_PSW, PSW_IE);
			wait_load();
			irq_i <= 16'h0000;
			chk21("line pc", {4'h0, 16'h1000 + 16'd16 + 16'(n), 1'b0}, pc_value_o);
			reg_chk("line vector", irq_entry_pkg::REG_VECTOR, 16'd16 + 16'(n));
		end
		$display("Test lines done");

		// Falling edge on the non-maskable pin while maskable requests are blocked
		@(posedge mclk_i);
		irq_i <= 16'h8000;
		nmi_n_i <= 1'b0;
		wait_load();
		chk21("nmi pc", {4'h0, 16'h1001, 1'b0}, pc_value_o);
		reg_chk("nmi vector", irq_entry_pkg::REG_VECTOR, 16'h0001);
		nmi_n_i <= 1'b1;
		irq_i <= 16'h0000;
		$display("Test nmi done");
		print_verdict();
	end
endmodule : interrupt_entry_dispatch_test
`default_nettype wire
